// ---- cpag_addr_gen.sv ----
// Coefficient pointer address generator top
`include "cpag_defines.svh"

module cpag_addr_gen (
  input wire logic mclk_i,
  input wire logic srst_i,
  // Pointer loads from the register write path
  input wire logic ptr_low_load_i,
  input wire logic page_load_i,
  input wire logic [`CPAG_PTR_W-1:0] load_data_i,
  // Request from the instruction decoder
  input wire logic req_valid_i,
  input wire cpag_pkg::cpag_mode_t req_mode_i,
  input wire cpag_pkg::cpag_space_t req_space_i,
  input wire logic req_long_i,
  input wire logic req_parallel_i,
  input wire logic req_bit_op_i,
  input wire logic [`CPAG_SEL_W-1:0] req_reg_sel_i,
  input wire logic req_coef_i,
  input wire logic req_move_i,
  input wire logic req_write_i,
  input wire logic [`CPAG_PTR_W-1:0] signed_offset_const_i,
  input wire logic [`CPAG_BANK_W-1:0] dual_bank_i,
  // Status and index sources
  input wire logic circ_en_i,
  input wire logic compat_mode_bit_i,
  input wire logic [`CPAG_PTR_W-1:0] coef_buffer_start_i,
  input wire logic [`CPAG_PTR_W-1:0] coef_buffer_size_i,
  input wire logic [`CPAG_PTR_W-1:0] temp_reg_zero_i,
  input wire logic [`CPAG_PTR_W-1:0] aux_reg_zero_i,
  // Results
  output logic addr_valid_o,
  output logic refused_o,
  output logic [`CPAG_ADDR_W-1:0] data_addr_o,
  output logic [`CPAG_PTR_W-1:0] io_addr_o,
  output logic io_valid_o,
  output logic [`CPAG_BIT_W-1:0] bit_num_o,
  output logic bit_valid_o,
  output logic coef_read_bus_en_o,
  output logic read_bus_c_en_o,
  output logic data_read_bus_d_en_o,
  output logic write_bus_e_en_o,
  output logic write_bus_f_en_o,
  output logic single_cycle_o,
  output logic extern_fault_o,
  output logic [`CPAG_PTR_W-1:0] coef_ptr_low_o,
  output logic [`CPAG_PAGE_W-1:0] coef_ptr_high_o
);

  // Highest legal bit number for a register selector
  function automatic logic [`CPAG_BIT_W-1:0] top_bit(input logic [`CPAG_SEL_W-1:0] sel);
    if (sel <= `CPAG_SEL_ACC_LAST)
      top_bit = `CPAG_ACC_TOP_BIT;
    else
      top_bit = `CPAG_REG16_TOP_BIT;
  endfunction

  // Selector names an accumulator, aux or temp register
  // All sixteen selector codes name a register, so this never refuses today
  function automatic logic sel_known(input logic [`CPAG_SEL_W-1:0] sel);
    sel_known = (sel <= `CPAG_SEL_ACC_LAST) || (sel <= `CPAG_SEL_AUX_LAST) ||
                (sel <= `CPAG_SEL_TMP_LAST);
  endfunction

  // Memory bank holding a data-space address
  function automatic logic [`CPAG_BANK_W-1:0] bank_of(input logic [`CPAG_ADDR_W-1:0] a);
    bank_of = a[`CPAG_BANK_LSB+`CPAG_BANK_W-1:`CPAG_BANK_LSB];
  endfunction

  // Architectural pointer state
  logic [`CPAG_PTR_W-1:0] coef_ptr_low_r;
  logic [`CPAG_PTR_W-1:0] coef_ptr_low_nxt;
  logic [`CPAG_PAGE_W-1:0] coef_ptr_high_r;
  logic [`CPAG_PAGE_W-1:0] coef_ptr_high_nxt;

  // Registered results
  logic addr_valid_r;
  logic refused_r;
  logic [`CPAG_ADDR_W-1:0] data_addr_r;
  logic [`CPAG_PTR_W-1:0] io_addr_r;
  logic io_valid_r;
  logic [`CPAG_BIT_W-1:0] bit_num_r;
  logic bit_valid_r;
  logic coef_bus_r;
  logic bus_c_r;
  logic bus_d_r;
  logic bus_e_r;
  logic bus_f_r;
  logic single_r;
  logic extern_r;

  // Mode decode
  // Codes 6 and 7 decode to no mode and are refused
  wire is_plain = (req_mode_i == cpag_pkg::CPAG_MODE_PLAIN);
  wire is_inc = (req_mode_i == cpag_pkg::CPAG_MODE_POST_INC);
  wire is_dec = (req_mode_i == cpag_pkg::CPAG_MODE_POST_DEC);
  wire is_off = (req_mode_i == cpag_pkg::CPAG_MODE_OFFSET);
  wire is_pre = (req_mode_i == cpag_pkg::CPAG_MODE_PRE_ADD);
  wire is_idx = (req_mode_i == cpag_pkg::CPAG_MODE_POST_IDX);
  wire is_k16 = is_off || is_pre;
  wire mode_known = is_plain || is_inc || is_dec || is_k16 || is_idx;

  // Space decode
  wire sp_data = (req_space_i == cpag_pkg::CPAG_SPACE_DATA);
  wire sp_mmr = (req_space_i == cpag_pkg::CPAG_SPACE_MMR);
  wire sp_bit = (req_space_i == cpag_pkg::CPAG_SPACE_REGBIT);
  wire sp_io = (req_space_i == cpag_pkg::CPAG_SPACE_IO);
  wire sp_dspace = sp_data || sp_mmr;

  // Coefficient access is a three-operand fetch or a move
  wire coef_acc = req_coef_i || req_move_i;

  // Step size: one word or bit, two for long words or bit pairs
  wire [`CPAG_PTR_W-1:0] step = req_long_i ? `CPAG_STEP_LONG : `CPAG_STEP_SHORT;

  // Index for the post-add coefficient mode follows the compat bit
  // The index is signed, so a negative index walks the pointer backwards
  wire [`CPAG_PTR_W-1:0] index_val =
    compat_mode_bit_i ? aux_reg_zero_i : temp_reg_zero_i;

  // Signed delta fed to the single step unit
  // Decrement is the negated step, so one adder serves every mode
  wire [`CPAG_PTR_W-1:0] delta =
    is_inc ? step :
    is_dec ? (~step + `CPAG_STEP_SHORT) :
    is_idx ? index_val :
    is_k16 ? signed_offset_const_i :
    16'h0000;

  // Sum of pointer and delta, linear or circular
  // The fold uses the buffer size; the start is only added to the address
  logic [`CPAG_PTR_W-1:0] stepped;

  cpag_step u_step (
    .ptr_i(coef_ptr_low_r),
    .delta_i(delta),
    .circ_i(circ_en_i),
    .size_i(coef_buffer_size_i),
    .sum_o(stepped)
  );

  // Pointer used for addressing: pre-add and offset use the sum
  wire [`CPAG_PTR_W-1:0] eff_ptr = is_k16 ? stepped : coef_ptr_low_r;

  // Buffer start only joins in circular mode
  wire [`CPAG_PTR_W-1:0] addr_low =
    circ_en_i ? (coef_buffer_start_i + eff_ptr) : eff_ptr;

  // Page rides on top and is never touched by the carry
  wire [`CPAG_ADDR_W-1:0] data_addr = {coef_ptr_high_r, addr_low};

  // Bit access legality: only bit ops on known registers in range
  // Limitation: a bit pair is not checked for its upper bit
  wire [`CPAG_BIT_W-1:0] bit_top = top_bit(req_reg_sel_i);
  wire bit_in_range =
    (eff_ptr[`CPAG_PTR_W-1:`CPAG_BIT_W] == 10'h000) &&
    (eff_ptr[`CPAG_BIT_W-1:0] <= bit_top);
  wire bit_ok = req_bit_op_i && sel_known(req_reg_sel_i) && bit_in_range;

  // Mode and space combinations that are refused
  // A refused request changes nothing but the refused strobe
  wire k16_bad = is_k16 && (sp_io || req_parallel_i);
  wire idx_bad = is_idx && !coef_acc;
  wire coef_bad = coef_acc && (!sp_data || is_k16);
  wire both_bad = req_coef_i && req_move_i;
  wire space_bad = sp_bit && !bit_ok;
  wire refuse = req_valid_i &&
    (!mode_known || k16_bad || idx_bad ||
     coef_bad || both_bad || space_bad);
  wire take = req_valid_i && !refuse;

  // Post modes and pre-add write the sum back; plain and offset keep it
  wire ptr_update = take && (is_inc || is_dec || is_idx || is_pre);

  // Coefficient operand placement against memory banks and limits
  // Memory limit and bank field are fixed choices held in the defines
  wire coef_internal = (data_addr < `CPAG_INT_MEM_TOP);
  wire bank_apart = (bank_of(data_addr) != dual_bank_i);

  // Move buses: reads on C and D, writes on E and F
  wire mv_rd = take && req_move_i && !req_write_i;
  wire mv_wr = take && req_move_i && req_write_i;

  // Pointer next value; a load from the write path beats an update
  always_comb
  begin
    coef_ptr_low_nxt = coef_ptr_low_r;
    if (ptr_low_load_i)
      coef_ptr_low_nxt = load_data_i;
    else if (ptr_update)
      coef_ptr_low_nxt = stepped;
  end

  // Page changes only by an explicit load, never by pointer carry
  always_comb
  begin
    coef_ptr_high_nxt = coef_ptr_high_r;
    if (page_load_i)
      coef_ptr_high_nxt = load_data_i[`CPAG_PAGE_W-1:0];
  end

  // Pointer register; wraps within its own 16 bits
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      coef_ptr_low_r <= `CPAG_PTR_RST;
    else
      coef_ptr_low_r <= coef_ptr_low_nxt;
  end

  // Page register
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      coef_ptr_high_r <= `CPAG_PAGE_RST;
    else
      coef_ptr_high_r <= coef_ptr_high_nxt;
  end

  // Strobe next values; a refused or idle cycle leaves them all low
  wire addr_valid_nxt = take && sp_dspace;
  wire io_valid_nxt = take && sp_io;
  wire bit_valid_nxt = take && sp_bit;

  // Coefficient bus group; an external target gets no bus at all
  wire coef_bus_nxt = take && req_coef_i && coef_internal;
  wire extern_nxt = take && req_coef_i && !coef_internal;
  wire single_nxt = coef_bus_nxt && bank_apart;

  // Move bus next values; a long move adds the high word
  wire bus_c_nxt = mv_rd && req_long_i;
  wire bus_d_nxt = mv_rd;
  wire bus_e_nxt = mv_wr;
  wire bus_f_nxt = mv_wr && req_long_i;

  // Request strobes, one cycle each
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      addr_valid_r <= 1'b0;
      refused_r <= 1'b0;
      io_valid_r <= 1'b0;
    end
    else
    begin
      addr_valid_r <= addr_valid_nxt;
      refused_r <= refuse;
      io_valid_r <= io_valid_nxt;
    end
  end

  // Held addresses; they change only on a taken request of their space
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      data_addr_r <= 23'h000000;
      io_addr_r <= 16'h0000;
    end
    else
    begin
      if (addr_valid_nxt)
        data_addr_r <= data_addr;
      if (io_valid_nxt)
        io_addr_r <= addr_low;
    end
  end

  // Bit number for register bit operations
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      bit_num_r <= 6'h00;
      bit_valid_r <= 1'b0;
    end
    else
    begin
      bit_valid_r <= bit_valid_nxt;
      if (bit_valid_nxt)
        bit_num_r <= eff_ptr[`CPAG_BIT_W-1:0];
    end
  end

  // Coefficient bus flops
  // The dedicated coefficient bus is only driven for internal targets
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      coef_bus_r <= 1'b0;
      single_r <= 1'b0;
      extern_r <= 1'b0;
    end
    else
    begin
      coef_bus_r <= coef_bus_nxt;
      single_r <= single_nxt;
      extern_r <= extern_nxt;
    end
  end

  // Move bus flops; moves never use the coefficient bus
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      bus_c_r <= 1'b0;
      bus_d_r <= 1'b0;
      bus_e_r <= 1'b0;
      bus_f_r <= 1'b0;
    end
    else
    begin
      bus_c_r <= bus_c_nxt;
      bus_d_r <= bus_d_nxt;
      bus_e_r <= bus_e_nxt;
      bus_f_r <= bus_f_nxt;
    end
  end

  // Outputs straight from flops
  assign addr_valid_o = addr_valid_r;
  assign refused_o = refused_r;
  assign data_addr_o = data_addr_r;
  assign io_addr_o = io_addr_r;
  assign io_valid_o = io_valid_r;
  assign bit_num_o = bit_num_r;
  assign bit_valid_o = bit_valid_r;

  // Bus enables and coefficient placement flags
  assign coef_read_bus_en_o = coef_bus_r;
  assign read_bus_c_en_o = bus_c_r;
  assign data_read_bus_d_en_o = bus_d_r;
  assign write_bus_e_en_o = bus_e_r;
  assign write_bus_f_en_o = bus_f_r;
  assign single_cycle_o = single_r;
  assign extern_fault_o = extern_r;

  // Live pointer registers
  assign coef_ptr_low_o = coef_ptr_low_r;
  assign coef_ptr_high_o = coef_ptr_high_r;

endmodule

// ---- cpag_defines.svh ----
// Constants for the coefficient pointer address generator
`ifndef CPAG_DEFINES_SVH
`define CPAG_DEFINES_SVH

`define CPAG_PTR_W 16
`define CPAG_PAGE_W 7
`define CPAG_ADDR_W 23
`define CPAG_BIT_W 6
`define CPAG_SEL_W 4
`define CPAG_BANK_W 3

// Register selector ranges for bit access
`define CPAG_SEL_ACC_LAST 4'h3
`define CPAG_SEL_AUX_LAST 4'hB
`define CPAG_SEL_TMP_LAST 4'hF
`define CPAG_ACC_TOP_BIT 6'h27
`define CPAG_REG16_TOP_BIT 6'h0F

// Post-modification steps
`define CPAG_STEP_SHORT 16'h0001
`define CPAG_STEP_LONG 16'h0002

// Bank field of a 23-bit address and top of internal memory
`define CPAG_BANK_LSB 13
`define CPAG_INT_MEM_TOP 23'h010000

// Reset values
`define CPAG_PTR_RST 16'h0000
`define CPAG_PAGE_RST 7'h00

`endif

// ---- cpag_pkg.sv ----
// Types shared by the coefficient pointer address generator
package cpag_pkg;

  typedef enum logic [2:0] {
    CPAG_MODE_PLAIN = 3'b000,
    CPAG_MODE_POST_INC = 3'b001,
    CPAG_MODE_POST_DEC = 3'b010,
    CPAG_MODE_OFFSET = 3'b011,
    CPAG_MODE_PRE_ADD = 3'b100,
    CPAG_MODE_POST_IDX = 3'b101
  } cpag_mode_t;

  typedef enum logic [1:0] {
    CPAG_SPACE_DATA = 2'b00,
    CPAG_SPACE_MMR = 2'b01,
    CPAG_SPACE_REGBIT = 2'b10,
    CPAG_SPACE_IO = 2'b11
  } cpag_space_t;

endpackage

// ---- cpag_step.sv ----
// Pointer step unit: linear or circular add of a signed delta
`include "cpag_defines.svh"

module cpag_step (
  input wire logic [`CPAG_PTR_W-1:0] ptr_i,
  input wire logic [`CPAG_PTR_W-1:0] delta_i,
  input wire logic circ_i,
  input wire logic [`CPAG_PTR_W-1:0] size_i,
  output logic [`CPAG_PTR_W-1:0] sum_o
);

  logic [`CPAG_PTR_W:0] raw;
  logic [`CPAG_PTR_W:0] size_ext;
  logic neg;
  logic over;

  // One extra bit keeps the sign of the raw sum for the circular fold
  assign raw = {1'b0, ptr_i} + {delta_i[`CPAG_PTR_W-1], delta_i};
  assign size_ext = {1'b0, size_i};
  assign neg = raw[`CPAG_PTR_W] & delta_i[`CPAG_PTR_W-1];
  assign over = !neg && (raw >= size_ext) && (size_i != 16'h0000);

  // Linear drops the carry; circular folds back into the buffer
  // Fold is single: deltas larger than the buffer are not reduced
  always_comb
  begin
    if (!circ_i)
      sum_o = raw[`CPAG_PTR_W-1:0];
    else if (neg)
      sum_o = raw[`CPAG_PTR_W-1:0] + size_i;
    else if (over)
      sum_o = raw[`CPAG_PTR_W-1:0] - size_i;
    else
      sum_o = raw[`CPAG_PTR_W-1:0];
  end

endmodule

// ---- cpag_sva.sv ----
// Port-level assertions for the coefficient pointer address generator
`include "cpag_defines.svh"

module cpag_sva (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic page_load_i,
  input wire logic ptr_low_load_i,
  input wire logic req_valid_i,
  input wire cpag_pkg::cpag_mode_t req_mode_i,
  input wire cpag_pkg::cpag_space_t req_space_i,
  input wire logic req_long_i,
  input wire logic req_parallel_i,
  input wire logic req_bit_op_i,
  input wire logic [3:0] req_reg_sel_i,
  input wire logic circ_en_i,
  input wire logic [2:0] dual_bank_i,
  input wire logic refused_o,
  input wire logic addr_valid_o,
  input wire logic io_valid_o,
  input wire logic coef_read_bus_en_o,
  input wire logic single_cycle_o,
  input wire logic [22:0] data_addr_o,
  input wire logic [15:0] io_addr_o,
  input wire logic [15:0] coef_ptr_low_o,
  input wire logic [6:0] coef_ptr_high_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Single domain, so reset masks every check
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);

  // Old pointer on the current page, then a step of one or two
  a_post_step: assert property (req_valid_i && req_mode_i == 3'h1 && req_space_i == 2'h0
    && !circ_en_i && !ptr_low_load_i |=> addr_valid_o
    && data_addr_o == {$past(coef_ptr_high_o), $past(coef_ptr_low_o)}
    && coef_ptr_low_o == $past(coef_ptr_low_o) + ($past(req_long_i) ? 16'h0002 : 16'h0001))
    else $error("post-increment address or step wrong");
  // Carries out of the pointer must never reach the page
  a_page_hold: assert property (!page_load_i |=> $stable(coef_ptr_high_o))
    else $error("page changed without a load");
  // Extension-coded offsets cannot share a cycle with another instruction
  a_k16_alone: assert property (req_valid_i && req_parallel_i && !ptr_low_load_i
    && req_mode_i inside {3'h3, 3'h4} |=> refused_o && $stable(coef_ptr_low_o))
    else $error("parallel offset request taken");
  // Bit number beyond the register's top bit is refused
  a_bit_top: assert property (req_valid_i && req_space_i == 2'h2 && req_mode_i < 3'h3
    && coef_ptr_low_o > (req_reg_sel_i > 4'h3 ? 16'h000F : 16'h0027) |=> refused_o)
    else $error("out-of-range bit number taken");
  a_bit_op_only: assert property (req_valid_i && req_space_i == 2'h2 && !req_bit_op_i
    |=> refused_o)
    else $error("bit access without bit instruction taken");
  // I/O word address is the bare pointer outside circular mode, page plays no part
  a_io_addr: assert property (io_valid_o && !$past(circ_en_i)
    |-> io_addr_o == $past(coef_ptr_low_o))
    else $error("io address differs from pointer");
  a_coef_int: assert property (coef_read_bus_en_o |-> data_addr_o < `CPAG_INT_MEM_TOP)
    else $error("coefficient bus used for external address");
  a_bank_split: assert property (single_cycle_o |-> coef_read_bus_en_o
    && data_addr_o[15:13] != $past(dual_bank_i))
    else $error("single cycle claimed with shared bank");
endmodule

bind cpag_addr_gen cpag_sva chk_i (.*);

// ---- cpag_dec_model.sv ----
// Instruction decoder model that presents requests to the address generator
module cpag_dec_model (
  input wire logic mclk_i,
  output logic req_valid_i,
  output cpag_pkg::cpag_mode_t req_mode_i,
  output cpag_pkg::cpag_space_t req_space_i,
  output logic req_long_i,
  output logic req_parallel_i,
  output logic req_bit_op_i,
  output logic [3:0] req_reg_sel_i,
  output logic req_coef_i,
  output logic req_move_i,
  output logic req_write_i,
  output logic [15:0] signed_offset_const_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle decoder from time zero
  initial
  begin
    req_mode_i = cpag_pkg::CPAG_MODE_PLAIN;
    req_space_i = cpag_pkg::CPAG_SPACE_DATA;
    {req_valid_i, req_long_i, req_parallel_i, req_bit_op_i, req_coef_i} = 5'h00;
    {req_move_i, req_write_i, req_reg_sel_i, signed_offset_const_i} = 22'h000000;
  end

  // Word: mode, space, flags, selector, offset; one cycle strobe off the edge
  task automatic issue(input logic [35:0] w);
    @(negedge mclk_i);
    req_mode_i = cpag_pkg::cpag_mode_t'(w[34:32]);
    req_space_i = cpag_pkg::cpag_space_t'(w[29:28]);
    // Parallel flag only where the bench asks for a faulty issue
    {req_long_i, req_parallel_i, req_bit_op_i} = w[25:23];
    {req_coef_i, req_move_i, req_write_i, req_reg_sel_i, signed_offset_const_i} = w[22:0];
    req_valid_i = 1'b1;
    @(negedge mclk_i);
    req_valid_i = 1'b0;
  endtask
endmodule

// ---- coef_pointer_addr_gen_tb_top.sv ----
// Self-checking bench for the coefficient pointer address generator
module coef_pointer_addr_gen_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic ptr_low_load_i = 1'b0;
  logic page_load_i = 1'b0;
  logic circ_en_i = 1'b0;
  logic compat_mode_bit_i = 1'b0;
  logic [15:0] load_data_i = 16'h0000;
  logic [15:0] coef_buffer_start_i = 16'h1000;
  logic [15:0] coef_buffer_size_i = 16'h0004;
  logic [15:0] temp_reg_zero_i = 16'h0010;
  logic [15:0] aux_reg_zero_i = 16'h0100;
  logic [2:0] dual_bank_i = 3'h2;
  logic req_valid_i, req_long_i, req_parallel_i, req_bit_op_i, req_coef_i, req_move_i;
  logic req_write_i, addr_valid_o, refused_o, io_valid_o, bit_valid_o, coef_read_bus_en_o;
  logic read_bus_c_en_o, data_read_bus_d_en_o, write_bus_e_en_o, write_bus_f_en_o;
  logic single_cycle_o, extern_fault_o;
  logic [3:0] req_reg_sel_i;
  logic [15:0] signed_offset_const_i, io_addr_o, coef_ptr_low_o;
  logic [22:0] data_addr_o;
  logic [5:0] bit_num_o;
  logic [6:0] coef_ptr_high_o;
  cpag_pkg::cpag_mode_t req_mode_i;
  cpag_pkg::cpag_space_t req_space_i;
  int err_total = 0;
  int tests_run = 0;
  // All strobes in one vector so a stray pulse is caught too
  wire [10:0] pl = {addr_valid_o, refused_o, io_valid_o, bit_valid_o, coef_read_bus_en_o,
    read_bus_c_en_o, data_read_bus_d_en_o, write_bus_e_en_o, write_bus_f_en_o,
    single_cycle_o, extern_fault_o};

  cpag_addr_gen uut (.*);
  cpag_dec_model dec (.*);

  // 10 MHz clock
  always #50 mclk_i = ~mclk_i;

  task automatic chk(input string n, input logic [22:0] e, input logic [22:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // One request, then strobes, address of its space and pointer
  task automatic op(input logic [35:0] w, input logic [10:0] ep, input logic [22:0] ea,
    input logic [15:0] eq);
    dec.issue(w);
    chk("strobes", 23'(ep), 23'(pl));
    if (!ep[9])
      chk("address", ea, w[29:28] == 2'h3 ? 23'(io_addr_o) :
        w[29] ? 23'(bit_num_o) : data_addr_o);
    chk("pointer", 23'(eq), 23'(coef_ptr_low_o));
  endtask

  // Page first, then pointer, both through the load path
  task automatic ld(input logic [6:0] h, input logic [15:0] p);
    @(negedge mclk_i);
    load_data_i = {9'h000, h};
    page_load_i = 1'b1;
    @(negedge mclk_i);
    page_load_i = 1'b0;
    ptr_low_load_i = 1'b1;
    load_data_i = p;
    @(negedge mclk_i);
    ptr_low_load_i = 1'b0;
    chk("page", 23'(h), 23'(coef_ptr_high_o));
  endtask

  task automatic t_ptr();
    ld(7'h05, 16'hFFFF);
    op(36'h100000000, 11'h400, 23'h05FFFF, 16'h0000);
    op(36'h102000000, 11'h400, 23'h050000, 16'h0002);
    op(36'h202000000, 11'h400, 23'h050002, 16'h0000);
    op(36'h210000000, 11'h400, 23'h050000, 16'hFFFF);
    op(36'h300000003, 11'h400, 23'h050002, 16'hFFFF);
    op(36'h40000FFFE, 11'h400, 23'h05FFFD, 16'hFFFD);
    op(36'h330000001, 11'h200, 23'h000000, 16'hFFFD);
    op(36'h401000002, 11'h200, 23'h000000, 16'hFFFD);
    chk("page", 23'h000005, 23'(coef_ptr_high_o));
    $display("test pointer modes done");
  endtask

  task automatic t_bit();
    ld(7'h05, 16'h0027);
    op(36'h030000000, 11'h100, 23'h000027, 16'h0027);
    op(36'h020800000, 11'h080, 23'h000027, 16'h0027);
    op(36'h020840000, 11'h200, 23'h000000, 16'h0027);
    op(36'h020000000, 11'h200, 23'h000000, 16'h0027);
    circ_en_i = 1'b1;
    ld(7'h05, 16'h0003);
    op(36'h100000000, 11'h400, 23'h051003, 16'h0000);
    op(36'h200000000, 11'h400, 23'h051000, 16'h0003);
    circ_en_i = 1'b0;
    $display("test bit io circular done");
  endtask

  task automatic t_coef();
    ld(7'h00, 16'h2000);
    op(36'h500400000, 11'h442, 23'h002000, 16'h2010);
    compat_mode_bit_i = 1'b1;
    dual_bank_i = 3'h1;
    op(36'h500400000, 11'h440, 23'h002010, 16'h2110);
    op(36'h500000000, 11'h200, 23'h000000, 16'h2110);
    ld(7'h01, 16'h2110);
    op(36'h100400000, 11'h401, 23'h012110, 16'h2111);
    op(36'h002200000, 11'h430, 23'h012111, 16'h2111);
    op(36'h002300000, 11'h40C, 23'h012111, 16'h2111);
    op(36'h000300000, 11'h408, 23'h012111, 16'h2111);
    $display("test coefficient fetch done");
  endtask

  // Mid-run reset clears pointer, page, held values and strobes
  task automatic t_rst();
    ld(7'h03, 16'h0040);
    op(36'h030000000, 11'h100, 23'h000040, 16'h0040);
    @(negedge mclk_i);
    srst_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    chk("reset strobes", 23'h000000, 23'(pl));
    chk("reset data address", 23'h000000, data_addr_o);
    chk("reset io address", 23'h000000, 23'(io_addr_o));
    chk("reset bit number", 23'h000000, 23'(bit_num_o));
    chk("reset pointer", 23'h000000, {coef_ptr_high_o, coef_ptr_low_o});
    srst_i = 1'b0;
    op(36'h100000000, 11'h400, 23'h000000, 16'h0001);
    $display("test mid-run reset done");
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Reset for six cycles, then the scenarios
  initial
  begin
    repeat (6) @(negedge mclk_i);
    srst_i = 1'b0;
    t_ptr();
    t_bit();
    t_coef();
    t_rst();
    conclude();
  end

  // Tests take about 75 cycles; cut a hang well after that
  initial
  begin
    #200000;
    err_total++;
    $display("ERROR watchdog expected finish seen hang");
    conclude();
  end
endmodule
